// *** bench/sba_checker.sv ***
`timescale 1ns/100ps
`default_nettype none
// ==========================================
// tenure checks on the shared bus lines
module sba_checker (
  input wire logic mclk,
  input wire logic rst_n,
  input wire logic br,
  input wire logic bg,
  input wire logic ta,
  input wire logic address_acknowledge_line,
  input wire logic address_retry_line,
  input wire logic d_ts,
  input wire logic d_ts_oe,
  input wire logic d_abb,
  input wire logic d_abb_oe,
  input wire logic f_abb,
  input wire logic f_abb_oe,
  input wire logic d_dbb,
  input wire logic d_dbb_oe,
  input wire logic f_dbb,
  input wire logic f_dbb_oe,
  input wire logic d_bg_oe,
  input wire logic d_dbg_oe,
  input wire logic d_br_oe,
  input wire logic d_address_retry_line,
  input wire logic d_address_retry_line_oe
);
  default clocking @(posedge mclk); endclocking
  default disable iff (!rst_n);
  wire own_ts = d_ts_oe & d_ts;

  ts_abb_a: assert property (own_ts |-> d_abb_oe && d_abb)
    else $error("transfer start without address busy");
  ts_pulse_a: assert property (own_ts |=> !own_ts)
    else $error("transfer start longer than one cycle");
  abb_release_a: assert property ((d_abb_oe && d_abb && address_acknowledge_line && !address_retry_line) |=>
    (d_abb_oe && !d_abb) ##1 !d_abb_oe) else $error("address busy not negated then released");
  abb_wait_a: assert property (own_ts |-> !$past(f_abb_oe && f_abb))
    else $error("address taken while other end busy");
  dbb_wait_a: assert property ($rose(d_dbb_oe && d_dbb) |-> !$past(f_dbb_oe && f_dbb))
    else $error("data bus taken while other end busy");
  dbb_release_a: assert property ((d_dbb_oe && !d_dbb) |-> $past(ta) ##1 !d_dbb_oe)
    else $error("data busy negation not after ta or not released");
  bg_after_br_a: assert property ($rose(d_bg_oe && bg) |-> $past(br))
    else $error("grant given without request");
  ext_grant_a: assert property ((d_br_oe && own_ts) |-> $past(bg))
    else $error("address tenure without external grant");
  dir_cfg_a: assert property (d_bg_oe == d_dbg_oe && d_br_oe != d_bg_oe)
    else $error("line directions disagree with mode");
  retry_ack_a: assert property ((d_address_retry_line_oe && d_address_retry_line) |-> address_acknowledge_line)
    else $error("retry without address acknowledge");
endmodule
`default_nettype wire

// *** bench/tb_system_bus_arbitration_tenure.sv ***
`timescale 1ns/100ps
`default_nettype none
module tb_system_bus_arbitration_tenure;
  logic mclk = 1'h0, rst_n = 1'h0, ext = 1'h0, hp = 1'h0, sn = 1'h0;
  logic ihit = 1'h0, coh = 1'h0, dlk = 1'h0, sl_rty = 1'h0;
  logic [1:0] req = '0, bu = '0;
  logic [4:0] tt [2] = '{'0, '0};
  logic [3:0] tsiz [2] = '{'0, '0};
  logic [63:0] wd [2] = '{'0, '0};
  logic [63:0] sl_rd = '0, s_rd = '0, st = 64'h17;
  logic [63:0] q [7][$];
  int n_mismatch = 0, n_tests = 0;
  wire [1:0] ack, wb, rv, dn, rt;
  wire [63:0] rd [2];
  wire [63:0] s_wd, sl_wd;
  wire s_ts, s_sn, s_int, s_mc, s_wv, sl_wv;
  sba_if bus ();
  always #4 mclk = ~mclk;
  // ==========================================
  // two ends and checker
  sba_dev u_sba_dev (.mclk, .rst_n, .bus, .ext_arb_cfg(ext), .host_port_en(hp), .snoop_en(sn),
    .m_req(req[0]), .m_tt(tt[0]), .m_tsiz(tsiz[0]), .m_burst(bu[0]), .m_wdata(wd[0]),
    .m_ack(ack[0]), .m_wbeat(wb[0]), .m_rdata(rd[0]), .m_rvalid(rv[0]), .m_done(dn[0]),
    .m_retry(rt[0]), .int_hit(ihit), .coh_hit(coh), .deadlock_hit(dlk), .s_rdata(s_rd),
    .s_ts, .s_snoop(s_sn), .s_int, .s_mc, .s_wdata(s_wd), .s_wvalid(s_wv));
  sba_far u_sba_far (.mclk, .rst_n, .bus, .ext_arb_cfg(ext), .host_port_en(hp),
    .m_req(req[1]), .m_tt(tt[1]), .m_tsiz(tsiz[1]), .m_burst(bu[1]), .m_wdata(wd[1]),
    .m_ack(ack[1]), .m_wbeat(wb[1]), .m_rdata(rd[1]), .m_rvalid(rv[1]), .m_done(dn[1]),
    .m_retry(rt[1]), .sl_retry(sl_rty), .sl_rdata(sl_rd), .sl_wdata(sl_wd), .sl_wvalid(sl_wv));
  sba_checker u_sba_checker (.mclk, .rst_n, .br(bus.br), .bg(bus.bg), .ta(bus.ta),
    .address_acknowledge_line(bus.address_acknowledge_line), .address_retry_line(bus.address_retry_line), .d_ts(bus.d_ts), .d_ts_oe(bus.d_ts_oe),
    .d_abb(bus.d_abb), .d_abb_oe(bus.d_abb_oe), .f_abb(bus.f_abb), .f_abb_oe(bus.f_abb_oe),
    .d_dbb(bus.d_dbb), .d_dbb_oe(bus.d_dbb_oe), .f_dbb(bus.f_dbb), .f_dbb_oe(bus.f_dbb_oe),
    .d_bg_oe(bus.d_bg_oe), .d_dbg_oe(bus.d_dbg_oe), .d_br_oe(bus.d_br_oe),
    .d_address_retry_line(bus.d_address_retry_line), .d_address_retry_line_oe(bus.d_address_retry_line_oe));
  // ==========================================
  // helpers
  function automatic logic [63:0] rnd();
    st = st ^ (st << 13);
    st = st ^ (st >> 7);
    st = st ^ (st << 17);
    return st;
  endfunction
  function automatic logic [63:0] nar(input logic [63:0] v);
    return hp ? {32'h0, v[31:0]} : v;
  endfunction
  task automatic chk(input int i, input logic [63:0] v);
    logic [63:0] e;
    e = q[i].size() ? q[i].pop_front() : ~v;
    n_tests++;
    if (e !== v) begin
      n_mismatch++;
      $display("ERROR t=%0t exp=%h got=%h", $time, e, v);
    end
  endtask
  task automatic results();
    foreach (q[i]) if (q[i].size() != 0) n_mismatch++;
    if (n_mismatch == 0 && n_tests > 0)
      $display("Regression OK");
    else
      $display("Regression broken");
    $finish;
  endtask
  // ==========================================
  // one transaction from end e, noting its results
  task automatic xfer(input int e, input logic wr, input logic b, input logic r);
    logic [63:0] d;
    int n;
    d = rnd();
    @(posedge mclk);
    tt[e] <= {d[4], wr, d[2:0]};
    tsiz[e] <= d[8:5];
    bu[e] <= b;
    req[e] <= 1'h1;
    if (e == 0) sl_rd <= d;
    if (e == 0) sl_rty <= r;
    if (e == 1) s_rd <= d;
    if (e == 1) ihit <= d[9];
    if (e == 1) coh <= r & sn;
    if (e == 1) dlk <= r & !sn;
    if (e == 1) repeat (r ? 2 : 1) q[6].push_back({61'h0, sn, d[9], !d[9]});
    if (!wr) repeat (b ? 4 : 1) q[1 + 2 * e].push_back(nar(d));
    if (r) q[4 + e].push_back(64'h1);
    q[4 + e].push_back(64'h0);
    n = 0;
    do begin @(posedge mclk); n++; end while (!ack[e] && n < 50);
    req[e] <= 1'h0;
    if (!ack[e]) n_mismatch++;
    n = 0;
    do begin
      @(posedge mclk);
      n++;
      if (rt[e]) {sl_rty, coh, dlk} <= 3'h0;
    end while (!dn[e] && n < 300);
    if (!dn[e]) begin n_mismatch++; results(); end
  endtask
  always @(posedge mclk) begin
    // write beat pulses also come on reads; only writes reach the slave
    if (wb[0] && tt[0][sba_pkg::TT_WR_BIT]) q[0].push_back(nar(wd[0]));
    if (wb[0]) wd[0] <= rnd();
    if (wb[1] && tt[1][sba_pkg::TT_WR_BIT]) q[2].push_back(nar(wd[1]));
    if (wb[1]) wd[1] <= rnd();
  end
  // ==========================================
  // result watcher
  always @(posedge mclk) if (rst_n) begin
    if (sl_wv) chk(0, sl_wd);
    if (rv[0]) chk(1, rd[0]);
    if (s_wv) chk(2, s_wd);
    if (rv[1]) chk(3, rd[1]);
    if (dn[0]) chk(4, 64'h0);
    if (rt[0]) chk(4, 64'h1);
    if (dn[1]) chk(5, 64'h0);
    if (rt[1]) chk(5, 64'h1);
    if (s_ts) chk(6, {61'h0, s_sn, s_int, s_mc});
  end
  // ==========================================
  // main sequence over arbiter and port modes
  initial begin
    for (int m = 0; m < 4; m++) begin
      rst_n <= 1'h0;
      ext <= m[0];
      hp <= m[1];
      sn <= m[0] ^ m[1];
      repeat (4) @(posedge mclk);
      rst_n <= 1'h1;
      for (int k = 0; k < 8; k++) xfer(k % 2, k[1], k[2], k % 3 == 0);
      fork
        xfer(0, m[0], 1'h1, 1'h0);
        xfer(1, !m[0], 1'h0, 1'h0);
      join
      repeat (12) @(posedge mclk);
    end
    results();
  end
endmodule
`default_nettype wire

// *** core/sba_busy_drv.sv ***
`timescale 1ns/100ps
`default_nettype none
// ==========================================
// busy line: held for the tenure, negated one cycle, then released
module sba_busy_drv (
  input wire logic mclk,
  input wire logic rst_n,
  input wire logic start,
  input wire logic done,
  output logic busy_o,
  output logic busy_oe
);
  logic act_ff;
  logic neg_ff;

  always_ff @(posedge mclk) begin
    if (!rst_n) begin
      act_ff <= 1'h0;
      neg_ff <= 1'h0;
    end else begin
      act_ff <= start | (act_ff & ~done);
      neg_ff <= act_ff & done;
    end
  end

  assign busy_o = act_ff;
  assign busy_oe = act_ff | neg_ff;
endmodule
`default_nettype wire

// *** core/sba_dev.sv ***
`timescale 1ns/100ps
`default_nettype none
// ==========================================
module sba_dev (
  input wire logic mclk,
  input wire logic rst_n,
  sba_if.dev bus,
  input wire logic ext_arb_cfg,
  input wire logic host_port_en,
  input wire logic snoop_en,
  input wire logic m_req,
  input wire logic [sba_pkg::TT_W-1:0] m_tt,
  input wire logic [sba_pkg::TSIZ_W-1:0] m_tsiz,
  input wire logic m_burst,
  input wire logic [sba_pkg::DATA_W-1:0] m_wdata,
  output logic m_ack,
  output logic m_wbeat,
  output logic [sba_pkg::DATA_W-1:0] m_rdata,
  output logic m_rvalid,
  output logic m_done,
  output logic m_retry,
  input wire logic int_hit,
  input wire logic coh_hit,
  input wire logic deadlock_hit,
  input wire logic [sba_pkg::DATA_W-1:0] s_rdata,
  output logic s_ts,
  output logic s_snoop,
  output logic s_int,
  output logic s_mc,
  output logic [sba_pkg::DATA_W-1:0] s_wdata,
  output logic s_wvalid
);
  sba_pkg::sba_mst_t st_ff, nxt_st;
  logic arb_ext_ff, narrow_ff, burst_ff;
  logic [sba_pkg::TT_W-1:0] tt_ff;
  logic [sba_pkg::TSIZ_W-1:0] tsiz_ff;
  logic [2:0] beat_ff;
  logic [sba_pkg::DATA_W-1:0] wd_ff, rd_ff;
  logic rvalid_ff, done_ff, retry_ff;
  logic ext_bg_ff, ext_dbg_ff, ext_apend_ff, ext_dpend_ff;
  logic sl_address_acknowledge_line_ff, sl_address_retry_line_ff, sl_pend_ff, sl_wr_ff, sl_ta_ff, sl_rdrv_ff;
  logic [2:0] sl_cnt_ff;
  logic [sba_pkg::DATA_W-1:0] sl_rd_ff, s_wd_ff;
  logic s_ts_ff, s_snoop_ff, s_int_ff, s_mc_ff, s_wvalid_ff;
  logic abb_o, abb_oe, dbb_o, dbb_oe;

  // ==========================================
  // decode
  wire own_addr = (st_ff == sba_pkg::ST_ADDR) || (st_ff == sba_pkg::ST_AWAIT);
  wire ext_abb = bus.abb & ~abb_oe;
  wire ext_dbb = bus.dbb & ~dbb_oe;
  wire ext_ts = bus.ts & (st_ff != sba_pkg::ST_ADDR);
  wire own_bg = arb_ext_ff ? bus.bg : ~ext_bg_ff;
  wire own_dbg = arb_ext_ff ? bus.dbg : ~(ext_dpend_ff | ext_dbg_ff);
  wire go_addr = (st_ff == sba_pkg::ST_REQ) & own_bg & ~ext_abb;
  wire go_data = (st_ff == sba_pkg::ST_DREQ) & own_dbg & ~ext_dbb;
  wire address_acknowledge_line_in = bus.address_acknowledge_line & (st_ff == sba_pkg::ST_AWAIT);
  wire ta_in = bus.ta & (st_ff == sba_pkg::ST_DATA);
  wire last = (beat_ff == sba_pkg::BEATS_SINGLE);
  wire wr = tt_ff[sba_pkg::TT_WR_BIT];
  wire mwr_drv = (st_ff == sba_pkg::ST_DATA) & wr;
  wire sl_last = (sl_cnt_ff == sba_pkg::BEATS_SINGLE);
  wire nxt_sl_ta = sl_pend_ff & ext_dbb & ~(sl_ta_ff & sl_last);
  wire nxt_ext_bg = ~arb_ext_ff & bus.br & ~own_addr & (st_ff != sba_pkg::ST_REQ);
  wire nxt_ext_dbg = ~arb_ext_ff & ext_dpend_ff & ~ext_dbb & (st_ff != sba_pkg::ST_DATA);
  wire want_retry = (snoop_en & coh_hit) | deadlock_hit;

  // ==========================================
  // master sequencer
  always_comb begin
    nxt_st = st_ff;
    unique case (st_ff)
      sba_pkg::ST_IDLE: if (m_req) nxt_st = sba_pkg::ST_REQ;
      sba_pkg::ST_REQ: if (go_addr) nxt_st = sba_pkg::ST_ADDR;
      sba_pkg::ST_ADDR: nxt_st = sba_pkg::ST_AWAIT;
      sba_pkg::ST_AWAIT: begin
        if (address_acknowledge_line_in) nxt_st = bus.address_retry_line ? sba_pkg::ST_REQ : sba_pkg::ST_DREQ;
      end
      sba_pkg::ST_DREQ: if (go_data) nxt_st = sba_pkg::ST_DATA;
      sba_pkg::ST_DATA: if (ta_in && last) nxt_st = sba_pkg::ST_IDLE;
      default: nxt_st = sba_pkg::ST_IDLE;
    endcase
  end

  always_ff @(posedge mclk) begin
    if (!rst_n) begin
      st_ff <= sba_pkg::ST_IDLE;
      arb_ext_ff <= ext_arb_cfg;
      narrow_ff <= host_port_en;
    end else begin
      st_ff <= nxt_st;
    end
  end

  always_ff @(posedge mclk) begin
    if (!rst_n) begin
      tt_ff <= '0;
      tsiz_ff <= '0;
      burst_ff <= 1'h0;
    end else if (m_ack) begin
      tt_ff <= m_tt;
      tsiz_ff <= m_tsiz;
      burst_ff <= m_burst;
    end
  end

  // ==========================================
  // data beats
  always_ff @(posedge mclk) begin
    if (!rst_n) begin
      beat_ff <= 3'h0;
      wd_ff <= '0;
    end else begin
      if (go_data) beat_ff <= sba_pkg::sba_beats(burst_ff);
      else if (ta_in) beat_ff <= beat_ff - 3'h1;
      if (m_wbeat) wd_ff <= m_wdata;
    end
  end

  always_ff @(posedge mclk) begin
    if (!rst_n) begin
      rd_ff <= '0;
      rvalid_ff <= 1'h0;
      done_ff <= 1'h0;
      retry_ff <= 1'h0;
    end else begin
      if (ta_in && !wr) rd_ff <= sba_pkg::sba_merge(narrow_ff, bus.dh, bus.dl);
      rvalid_ff <= ta_in & ~wr;
      done_ff <= ta_in & last;
      retry_ff <= address_acknowledge_line_in & bus.address_retry_line;
    end
  end

  // ==========================================
  // internal arbiter
  always_ff @(posedge mclk) begin
    if (!rst_n) begin
      ext_bg_ff <= 1'h0;
      ext_dbg_ff <= 1'h0;
      ext_apend_ff <= 1'h0;
      ext_dpend_ff <= 1'h0;
    end else begin
      ext_bg_ff <= nxt_ext_bg;
      ext_dbg_ff <= nxt_ext_dbg;
      ext_apend_ff <= ext_ts | (ext_apend_ff & ~bus.address_acknowledge_line);
      if (ext_apend_ff && bus.address_acknowledge_line && !bus.address_retry_line && !arb_ext_ff) ext_dpend_ff <= 1'h1;
      else if (ext_dbg_ff && ext_dbb) ext_dpend_ff <= 1'h0;
    end
  end

  // ==========================================
  // slave side for external tenures
  always_ff @(posedge mclk) begin
    if (!rst_n) begin
      sl_address_acknowledge_line_ff <= 1'h0;
      sl_address_retry_line_ff <= 1'h0;
      sl_wr_ff <= 1'h0;
      sl_cnt_ff <= 3'h0;
      sl_pend_ff <= 1'h0;
    end else begin
      sl_address_acknowledge_line_ff <= ext_ts;
      sl_address_retry_line_ff <= ext_ts & want_retry;
      if (ext_ts) begin
        sl_wr_ff <= bus.tt[sba_pkg::TT_WR_BIT];
        sl_cnt_ff <= sba_pkg::sba_beats(bus.burst_indicator_line);
      end else if (sl_ta_ff) begin
        sl_cnt_ff <= sl_cnt_ff - 3'h1;
      end
      if (sl_address_acknowledge_line_ff && !sl_address_retry_line_ff) sl_pend_ff <= 1'h1;
      else if (sl_ta_ff && sl_last) sl_pend_ff <= 1'h0;
    end
  end

  always_ff @(posedge mclk) begin
    if (!rst_n) begin
      sl_ta_ff <= 1'h0;
      sl_rdrv_ff <= 1'h0;
      sl_rd_ff <= '0;
      s_wd_ff <= '0;
      s_wvalid_ff <= 1'h0;
    end else begin
      sl_ta_ff <= nxt_sl_ta;
      sl_rdrv_ff <= nxt_sl_ta & ~sl_wr_ff;
      sl_rd_ff <= s_rdata;
      if (sl_ta_ff && sl_wr_ff) s_wd_ff <= sba_pkg::sba_merge(narrow_ff, bus.dh, bus.dl);
      s_wvalid_ff <= sl_ta_ff & sl_wr_ff;
    end
  end

  always_ff @(posedge mclk) begin
    if (!rst_n) begin
      s_ts_ff <= 1'h0;
      s_snoop_ff <= 1'h0;
      s_int_ff <= 1'h0;
      s_mc_ff <= 1'h0;
    end else begin
      s_ts_ff <= ext_ts;
      s_snoop_ff <= ext_ts & snoop_en;
      s_int_ff <= ext_ts & int_hit;
      s_mc_ff <= ext_ts & ~int_hit;
    end
  end

  // ==========================================
  // busy lines
  sba_busy_drv u_abb (
    .mclk(mclk),
    .rst_n(rst_n),
    .start(go_addr),
    .done(address_acknowledge_line_in),
    .busy_o(abb_o),
    .busy_oe(abb_oe)
  );

  sba_busy_drv u_dbb (
    .mclk(mclk),
    .rst_n(rst_n),
    .start(go_data),
    .done(ta_in & last),
    .busy_o(dbb_o),
    .busy_oe(dbb_oe)
  );

  // ==========================================
  // pin drive
  assign bus.d_br = (st_ff == sba_pkg::ST_REQ);
  assign bus.d_br_oe = arb_ext_ff;
  assign bus.d_bg = ext_bg_ff;
  assign bus.d_bg_oe = ~arb_ext_ff;
  assign bus.d_dbg = ext_dbg_ff;
  assign bus.d_dbg_oe = ~arb_ext_ff;
  assign bus.d_abb = abb_o;
  assign bus.d_abb_oe = abb_oe;
  assign bus.d_dbb = dbb_o;
  assign bus.d_dbb_oe = dbb_oe;
  assign bus.d_ts = 1'h1;
  assign bus.d_ts_oe = (st_ff == sba_pkg::ST_ADDR);
  assign bus.d_address_acknowledge_line = sl_address_acknowledge_line_ff;
  assign bus.d_address_acknowledge_line_oe = sl_address_acknowledge_line_ff;
  assign bus.d_address_retry_line = sl_address_retry_line_ff;
  assign bus.d_address_retry_line_oe = sl_address_acknowledge_line_ff;
  assign bus.d_ta = sl_ta_ff;
  assign bus.d_ta_oe = sl_ta_ff;
  assign bus.d_att_oe = own_addr;
  assign bus.d_tt = tt_ff;
  assign bus.d_tsiz = tsiz_ff;
  assign bus.d_burst_indicator_line = burst_ff;
  assign bus.d_dh = sba_pkg::sba_hi(narrow_ff, sl_rdrv_ff ? sl_rd_ff : wd_ff);
  assign bus.d_dl = sl_rdrv_ff ? sl_rd_ff[sba_pkg::WORD_W-1:0] : wd_ff[sba_pkg::WORD_W-1:0];
  assign bus.d_dh_oe = mwr_drv | sl_rdrv_ff;
  assign bus.d_dl_oe = (mwr_drv | sl_rdrv_ff) & ~narrow_ff;

  // ==========================================
  // user side
  assign m_ack = (st_ff == sba_pkg::ST_IDLE) & m_req;
  assign m_wbeat = go_data | (ta_in & ~last);
  assign m_rdata = rd_ff;
  assign m_rvalid = rvalid_ff;
  assign m_done = done_ff;
  assign m_retry = retry_ff;
  assign s_ts = s_ts_ff;
  assign s_snoop = s_snoop_ff;
  assign s_int = s_int_ff;
  assign s_mc = s_mc_ff;
  assign s_wdata = s_wd_ff;
  assign s_wvalid = s_wvalid_ff;
endmodule
`default_nettype wire

// *** core/sba_far.sv ***
`timescale 1ns/100ps
`default_nettype none
// ==========================================
// far end: external arbiter, external master and slave
module sba_far (
  input wire logic mclk,
  input wire logic rst_n,
  sba_if.far bus,
  input wire logic ext_arb_cfg,
  input wire logic host_port_en,
  input wire logic m_req,
  input wire logic [sba_pkg::TT_W-1:0] m_tt,
  input wire logic [sba_pkg::TSIZ_W-1:0] m_tsiz,
  input wire logic m_burst,
  input wire logic [sba_pkg::DATA_W-1:0] m_wdata,
  output logic m_ack,
  output logic m_wbeat,
  output logic [sba_pkg::DATA_W-1:0] m_rdata,
  output logic m_rvalid,
  output logic m_done,
  output logic m_retry,
  input wire logic sl_retry,
  input wire logic [sba_pkg::DATA_W-1:0] sl_rdata,
  output logic [sba_pkg::DATA_W-1:0] sl_wdata,
  output logic sl_wvalid
);
  sba_pkg::sba_mst_t st_ff, nxt_st;
  logic arb_ext_ff, narrow_ff, burst_ff, rvalid_ff, done_ff, retry_ff;
  logic [sba_pkg::TT_W-1:0] tt_ff;
  logic [sba_pkg::TSIZ_W-1:0] tsiz_ff;
  logic [2:0] beat_ff, sl_cnt_ff;
  logic [sba_pkg::DATA_W-1:0] wd_ff, rd_ff, sl_rd_ff, sl_wd_ff;
  logic bg_ff, dbg_ff, dev_apend_ff, dev_dpend_ff, sl_address_acknowledge_line_ff, sl_address_retry_line_ff;
  logic sl_pend_ff, sl_wr_ff, sl_ta_ff, sl_rdrv_ff, sl_wv_ff;
  logic abb_o, abb_oe, dbb_o, dbb_oe;

  wire own_addr = (st_ff == sba_pkg::ST_ADDR) || (st_ff == sba_pkg::ST_AWAIT);
  wire dev_abb = bus.abb & ~abb_oe;
  wire dev_dbb = bus.dbb & ~dbb_oe;
  wire dev_ts = bus.ts & (st_ff != sba_pkg::ST_ADDR);
  wire own_bg = arb_ext_ff ? ~bg_ff : bus.bg;
  wire own_dbg = arb_ext_ff ? ~(dev_dpend_ff | dbg_ff) : bus.dbg;
  wire go_addr = (st_ff == sba_pkg::ST_REQ) & own_bg & ~dev_abb;
  wire go_data = (st_ff == sba_pkg::ST_DREQ) & own_dbg & ~dev_dbb;
  wire address_acknowledge_line_in = bus.address_acknowledge_line & (st_ff == sba_pkg::ST_AWAIT);
  wire ta_in = bus.ta & (st_ff == sba_pkg::ST_DATA);
  wire last = (beat_ff == sba_pkg::BEATS_SINGLE);
  wire wr = tt_ff[sba_pkg::TT_WR_BIT];
  wire sl_last = (sl_cnt_ff == sba_pkg::BEATS_SINGLE);
  wire nxt_sl_ta = sl_pend_ff & dev_dbb & ~(sl_ta_ff & sl_last);
  wire mwr_drv = (st_ff == sba_pkg::ST_DATA) & wr;

  // ==========================================
  // master sequencer
  always_comb begin
    nxt_st = st_ff;
    unique case (st_ff)
      sba_pkg::ST_IDLE: if (m_req) nxt_st = sba_pkg::ST_REQ;
      sba_pkg::ST_REQ: if (go_addr) nxt_st = sba_pkg::ST_ADDR;
      sba_pkg::ST_ADDR: nxt_st = sba_pkg::ST_AWAIT;
      sba_pkg::ST_AWAIT: begin
        if (address_acknowledge_line_in) nxt_st = bus.address_retry_line ? sba_pkg::ST_REQ : sba_pkg::ST_DREQ;
      end
      sba_pkg::ST_DREQ: if (go_data) nxt_st = sba_pkg::ST_DATA;
      sba_pkg::ST_DATA: if (ta_in && last) nxt_st = sba_pkg::ST_IDLE;
      default: nxt_st = sba_pkg::ST_IDLE;
    endcase
  end

  always_ff @(posedge mclk) begin
    if (!rst_n) begin
      st_ff <= sba_pkg::ST_IDLE;
      arb_ext_ff <= ext_arb_cfg;
      narrow_ff <= host_port_en;
      {tt_ff, tsiz_ff, burst_ff, beat_ff, wd_ff, rd_ff} <= '0;
      {rvalid_ff, done_ff, retry_ff} <= '0;
    end else begin
      st_ff <= nxt_st;
      if (m_ack) {tt_ff, tsiz_ff, burst_ff} <= {m_tt, m_tsiz, m_burst};
      if (go_data) beat_ff <= sba_pkg::sba_beats(burst_ff);
      else if (ta_in) beat_ff <= beat_ff - 3'h1;
      if (m_wbeat) wd_ff <= m_wdata;
      if (ta_in && !wr) rd_ff <= sba_pkg::sba_merge(narrow_ff, bus.dh, bus.dl);
      rvalid_ff <= ta_in & ~wr;
      done_ff <= ta_in & last;
      retry_ff <= address_acknowledge_line_in & bus.address_retry_line;
    end
  end

  // ==========================================
  // external arbiter and slave
  always_ff @(posedge mclk) begin
    if (!rst_n) begin
      {bg_ff, dbg_ff, dev_apend_ff, dev_dpend_ff} <= '0;
      {sl_address_acknowledge_line_ff, sl_address_retry_line_ff, sl_pend_ff, sl_wr_ff, sl_cnt_ff} <= '0;
      {sl_ta_ff, sl_rdrv_ff, sl_wv_ff, sl_rd_ff, sl_wd_ff} <= '0;
    end else begin
      bg_ff <= arb_ext_ff & bus.br & ~own_addr & (st_ff != sba_pkg::ST_REQ);
      dbg_ff <= arb_ext_ff & dev_dpend_ff & ~dev_dbb & (st_ff != sba_pkg::ST_DATA);
      dev_apend_ff <= dev_ts | (dev_apend_ff & ~bus.address_acknowledge_line);
      if (dev_apend_ff && bus.address_acknowledge_line && !bus.address_retry_line && arb_ext_ff) dev_dpend_ff <= 1'h1;
      else if (dbg_ff && dev_dbb) dev_dpend_ff <= 1'h0;
      sl_address_acknowledge_line_ff <= dev_ts;
      sl_address_retry_line_ff <= dev_ts & sl_retry;
      if (dev_ts) begin
        sl_wr_ff <= bus.tt[sba_pkg::TT_WR_BIT];
        sl_cnt_ff <= sba_pkg::sba_beats(bus.burst_indicator_line);
      end else if (sl_ta_ff) begin
        sl_cnt_ff <= sl_cnt_ff - 3'h1;
      end
      if (sl_address_acknowledge_line_ff && !sl_address_retry_line_ff) sl_pend_ff <= 1'h1;
      else if (sl_ta_ff && sl_last) sl_pend_ff <= 1'h0;
      sl_ta_ff <= nxt_sl_ta;
      sl_rdrv_ff <= nxt_sl_ta & ~sl_wr_ff;
      sl_rd_ff <= sl_rdata;
      if (sl_ta_ff && sl_wr_ff) sl_wd_ff <= sba_pkg::sba_merge(narrow_ff, bus.dh, bus.dl);
      sl_wv_ff <= sl_ta_ff & sl_wr_ff;
    end
  end

  sba_busy_drv u_abb (
    .mclk(mclk),
    .rst_n(rst_n),
    .start(go_addr),
    .done(address_acknowledge_line_in),
    .busy_o(abb_o),
    .busy_oe(abb_oe)
  );

  sba_busy_drv u_dbb (
    .mclk(mclk),
    .rst_n(rst_n),
    .start(go_data),
    .done(ta_in & last),
    .busy_o(dbb_o),
    .busy_oe(dbb_oe)
  );

  // ==========================================
  // pin drive
  assign bus.f_br = (st_ff == sba_pkg::ST_REQ);
  assign bus.f_br_oe = ~arb_ext_ff;
  assign bus.f_bg = bg_ff;
  assign bus.f_bg_oe = arb_ext_ff;
  assign bus.f_dbg = dbg_ff;
  assign bus.f_dbg_oe = arb_ext_ff;
  assign bus.f_abb = abb_o;
  assign bus.f_abb_oe = abb_oe;
  assign bus.f_dbb = dbb_o;
  assign bus.f_dbb_oe = dbb_oe;
  assign bus.f_ts = 1'h1;
  assign bus.f_ts_oe = (st_ff == sba_pkg::ST_ADDR);
  assign bus.f_address_acknowledge_line = sl_address_acknowledge_line_ff;
  assign bus.f_address_acknowledge_line_oe = sl_address_acknowledge_line_ff;
  assign bus.f_address_retry_line = sl_address_retry_line_ff;
  assign bus.f_address_retry_line_oe = sl_address_acknowledge_line_ff;
  assign bus.f_ta = sl_ta_ff;
  assign bus.f_ta_oe = sl_ta_ff;
  assign bus.f_att_oe = own_addr;
  assign bus.f_tt = tt_ff;
  assign bus.f_tsiz = tsiz_ff;
  assign bus.f_burst_indicator_line = burst_ff;
  assign bus.f_dh = sba_pkg::sba_hi(narrow_ff, sl_rdrv_ff ? sl_rd_ff : wd_ff);
  assign bus.f_dl = sl_rdrv_ff ? sl_rd_ff[sba_pkg::WORD_W-1:0] : wd_ff[sba_pkg::WORD_W-1:0];
  assign bus.f_dh_oe = mwr_drv | sl_rdrv_ff;
  assign bus.f_dl_oe = (mwr_drv | sl_rdrv_ff) & ~narrow_ff;

  assign m_ack = (st_ff == sba_pkg::ST_IDLE) & m_req;
  assign m_wbeat = go_data | (ta_in & ~last);
  assign m_rdata = rd_ff;
  assign m_rvalid = rvalid_ff;
  assign m_done = done_ff;
  assign m_retry = retry_ff;
  assign sl_wdata = sl_wd_ff;
  assign sl_wvalid = sl_wv_ff;
endmodule
`default_nettype wire

// *** core/sba_if.sv ***
`timescale 1ns/100ps
`default_nettype none
// ==========================================
// shared bus lines, resolved from both ends
interface sba_if;
  logic br, bg, dbg, abb, dbb, ts, address_acknowledge_line, address_retry_line, ta, burst_indicator_line;
  logic [sba_pkg::TT_W-1:0] tt, d_tt, f_tt;
  logic [sba_pkg::TSIZ_W-1:0] tsiz, d_tsiz, f_tsiz;
  logic [sba_pkg::WORD_W-1:0] dh, dl, d_dh, d_dl, f_dh, f_dl;
  logic d_br, d_br_oe, d_bg, d_bg_oe, d_dbg, d_dbg_oe, d_abb, d_abb_oe;
  logic d_dbb, d_dbb_oe, d_ts, d_ts_oe, d_address_acknowledge_line, d_address_acknowledge_line_oe, d_address_retry_line, d_address_retry_line_oe;
  logic d_ta, d_ta_oe, d_burst_indicator_line, d_att_oe, d_dh_oe, d_dl_oe;
  logic f_br, f_br_oe, f_bg, f_bg_oe, f_dbg, f_dbg_oe, f_abb, f_abb_oe;
  logic f_dbb, f_dbb_oe, f_ts, f_ts_oe, f_address_acknowledge_line, f_address_acknowledge_line_oe, f_address_retry_line, f_address_retry_line_oe;
  logic f_ta, f_ta_oe, f_burst_indicator_line, f_att_oe, f_dh_oe, f_dl_oe;

  // undriven lines read as negated
  assign br = (d_br_oe & d_br) | (f_br_oe & f_br);
  assign bg = (d_bg_oe & d_bg) | (f_bg_oe & f_bg);
  assign dbg = (d_dbg_oe & d_dbg) | (f_dbg_oe & f_dbg);
  assign abb = (d_abb_oe & d_abb) | (f_abb_oe & f_abb);
  assign dbb = (d_dbb_oe & d_dbb) | (f_dbb_oe & f_dbb);
  assign ts = (d_ts_oe & d_ts) | (f_ts_oe & f_ts);
  assign address_acknowledge_line = (d_address_acknowledge_line_oe & d_address_acknowledge_line) | (f_address_acknowledge_line_oe & f_address_acknowledge_line);
  assign address_retry_line = (d_address_retry_line_oe & d_address_retry_line) | (f_address_retry_line_oe & f_address_retry_line);
  assign ta = (d_ta_oe & d_ta) | (f_ta_oe & f_ta);
  assign burst_indicator_line = (d_att_oe & d_burst_indicator_line) | (f_att_oe & f_burst_indicator_line);
  assign tt = d_att_oe ? d_tt : (f_att_oe ? f_tt : '0);
  assign tsiz = d_att_oe ? d_tsiz : (f_att_oe ? f_tsiz : '0);
  assign dh = d_dh_oe ? d_dh : (f_dh_oe ? f_dh : '0);
  assign dl = d_dl_oe ? d_dl : (f_dl_oe ? f_dl : '0);

  modport dev (input br, bg, dbg, abb, dbb, ts, address_acknowledge_line, address_retry_line, ta, burst_indicator_line, tt, tsiz, dh, dl,
    output d_br, d_br_oe, d_bg, d_bg_oe, d_dbg, d_dbg_oe, d_abb, d_abb_oe,
    d_dbb, d_dbb_oe, d_ts, d_ts_oe, d_address_acknowledge_line, d_address_acknowledge_line_oe, d_address_retry_line, d_address_retry_line_oe,
    d_ta, d_ta_oe, d_burst_indicator_line, d_att_oe, d_dh_oe, d_dl_oe, d_tt, d_tsiz, d_dh, d_dl);
  modport far (input br, bg, dbg, abb, dbb, ts, address_acknowledge_line, address_retry_line, ta, burst_indicator_line, tt, tsiz, dh, dl,
    output f_br, f_br_oe, f_bg, f_bg_oe, f_dbg, f_dbg_oe, f_abb, f_abb_oe,
    f_dbb, f_dbb_oe, f_ts, f_ts_oe, f_address_acknowledge_line, f_address_acknowledge_line_oe, f_address_retry_line, f_address_retry_line_oe,
    f_ta, f_ta_oe, f_burst_indicator_line, f_att_oe, f_dh_oe, f_dl_oe, f_tt, f_tsiz, f_dh, f_dl);
endinterface
`default_nettype wire

// *** core/sba_pkg.sv ***
// ==========================================
// shared constants and types
package sba_pkg;
  localparam int WORD_W = 32;
  localparam int DATA_W = 64;
  localparam int TT_W = 5;
  localparam int TSIZ_W = 4;
  localparam int TT_WR_BIT = 3;
  localparam logic [2:0] BEATS_BURST = 3'h4;
  localparam logic [2:0] BEATS_SINGLE = 3'h1;

  typedef enum logic [2:0] {
    ST_IDLE,
    ST_REQ,
    ST_ADDR,
    ST_AWAIT,
    ST_DREQ,
    ST_DATA
  } sba_mst_t;

  // ==========================================
  // helpers
  function automatic logic [2:0] sba_beats(input logic burst);
    return burst ? BEATS_BURST : BEATS_SINGLE;
  endfunction

  function automatic logic [DATA_W-1:0] sba_merge(input logic narrow,
      input logic [WORD_W-1:0] hi, input logic [WORD_W-1:0] lo);
    return narrow ? {{WORD_W{1'h0}}, hi} : {hi, lo};
  endfunction

  function automatic logic [WORD_W-1:0] sba_hi(input logic narrow,
      input logic [DATA_W-1:0] w);
    return narrow ? w[WORD_W-1:0] : w[DATA_W-1:WORD_W];
  endfunction
endpackage
